// [rtl/spisd_pkg.sv]
// Package with register map, field positions and timing constants of the SPI status/data block
// Functional notes
// R1 - Receive-full sets at transfer end; cleared by flagged status read then data read.
// R2 - Transmit-empty high while buffer has room; cleared by flagged status read then data write.
// R3 - Data write ignored unless status was read earlier with transmit-empty set.
// R4 - Transmit-empty with its interrupt enable raises an interrupt request.
// R5 - Transmit-empty sets whenever a byte moves from buffer into shifter.
// R6 - Idle block passes a written byte to shifter; transmit-empty returns within two cycles.
// R7 - Shifter done with empty buffer: transmit-empty stays set, nothing moves.
// R8 - Mode fault sets on select low only when master, fault detect on, select output off.
// R9 - Mode fault clears after flagged status read followed by control register one write.
// R10 - Unimplemented status bits read zero; status writes do nothing.
// R11 - Data read returns receive buffer; write loads transmit buffer; master starts transfer.
// R12 - Transfer ending before receive buffer is read keeps old byte, drops new one.
// R13 - No overrun flag or indication exists.
// R14 - Sample on one serial edge, change output half cycle later; eight bits each way.
// R15 - Transfer end moves received byte to receive buffer and sets receive-full.
// R16 - Byte waiting at transfer end loads shifter, sets transmit-empty, starts next transfer.
// R17 - Most significant bit first by default; lsb-first enable reverses order.
// R18 - External master holds slave select low for the whole transfer.
// R19 - Clock phase 0 needs select high between transfers; phase 1 may keep it low.
// R20 - Both directions double buffered.
// R21 - Mode fault clears master select and disables clock and data output drivers; code then enables the MISO driver while select stays low.
// R22 - Receive/fault enable gates receive-full and mode fault onto the interrupt.
// R23 - A status read arms only the clear of flags that are set at that read.
package spisd_pkg;
    localparam logic [3:0] ADR_CTRL1  = 4'h0;
    localparam logic [3:0] ADR_FLAGS  = 4'h3;
    localparam logic [3:0] ADR_BUFFER = 4'h5;
    localparam logic [3:0] ADR_DIV    = 4'h6;
    localparam int CTL_RX_FAULT_IRQ_EN = 7;
    localparam int CTL_SPI_ENABLE      = 6;
    localparam int CTL_TX_IRQ_EN       = 5;
    localparam int CTL_MASTER_SELECT   = 4;
    localparam int CTL_CLOCK_POLARITY  = 3;
    localparam int CTL_CLOCK_PHASE     = 2;
    localparam int CTL_SELECT_OUT_EN   = 1;
    localparam int CTL_LSB_FIRST_EN    = 0;
    localparam int CTL_FAULT_DETECT_EN = 8;
    localparam int FLG_RX_FULL         = 7;
    localparam int FLG_TX_EMPTY        = 5;
    localparam int FLG_MODE_FAULT      = 4;
    localparam logic [8:0] CTRL1_RESET = 9'h000;
    localparam logic [7:0] DIV_RESET   = 8'h03;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam int BITS_PER_XFER       = 8;
    localparam int CLK_PERIOD_NS       = 100;
    localparam int IDLE_LOAD_MAX_NS    = 200;
    localparam int IDLE_LOAD_CYCLES    = IDLE_LOAD_MAX_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_RUN} spisd_state_e;
endpackage

// [rtl/spisd_core.sv]
// SPI status flags, double buffers and transfer sequencer behind a classic Wishbone slave
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module spisd_core
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [3:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    input  wire logic       sel_n_i,
    output logic            sel_n_o,
    output logic            sel_n_oe_o,
    output logic            irq_o
);
    logic [8:0]  ctrl_r;
    logic [7:0]  div_r;
    logic [7:0]  txbuf_r;
    logic        txfull_r;
    logic [7:0]  rxbuf_r;
    logic        rx_full_flag_r;
    logic        mode_fault_flag_r;
    logic        arm_rx_r;
    logic        arm_tx_r;
    logic        arm_fault_r;
    logic [7:0]  shift_r;
    logic [3:0]  edge_cnt_r;
    logic [7:0]  div_cnt_r;
    logic        sck_r;
    logic        miso_bit_r;
    logic        sample_edge;
    logic        last_bit;
    logic        out_r;
    spisd_pkg::spisd_state_e state_r;
    logic [1:0]  sck_s;
    logic [1:0]  mosi_s;
    logic [1:0]  miso_s;
    logic [1:0]  sel_s;
    logic        sck_d_r;
    logic        sel_d_r;

    logic        acc;
    logic        wr_ok;
    logic        rd_ok;
    logic        tx_empty_flag;
    logic        master;
    logic        phase;
    logic        fault_cond;
    logic        load;
    logic        done;
    logic        lead_edge;
    logic        trail_edge;
    logic        sin;
    logic        tick;
    logic        sel_fall;

    assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ok   = acc && wb_we_i && wb_sel_i[0];
    assign rd_ok   = acc && !wb_we_i;
    assign master  = ctrl_r[spisd_pkg::CTL_MASTER_SELECT];
    assign phase   = ctrl_r[spisd_pkg::CTL_CLOCK_PHASE];
    assign tx_empty_flag = !txfull_r; // R2 R20

    function automatic logic [7:0] rd_mux(input logic [3:0] a);
        unique case (a)
            spisd_pkg::ADR_CTRL1:  rd_mux = ctrl_r[7:0];
            spisd_pkg::ADR_FLAGS:  rd_mux = {rx_full_flag_r, 1'b0, tx_empty_flag, mode_fault_flag_r, 4'h0}; // R10 R13
            spisd_pkg::ADR_BUFFER: rd_mux = rxbuf_r; // R11
            spisd_pkg::ADR_DIV:    rd_mux = div_r;
            4'h1:                  rd_mux = {3'h0, ctrl_r[spisd_pkg::CTL_FAULT_DETECT_EN], 4'h0};
            default:               rd_mux = 8'h00;
        endcase
    endfunction

    // Single-cycle ack; unmapped addresses ack and read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= acc;
            if (rd_ok)
                wb_dat_o <= {24'h0, rd_mux(wb_adr_i)};
        end
    end

    // Pin inputs pass two flops first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_s  <= 2'b00;
            mosi_s <= 2'b00;
            miso_s <= 2'b00;
            sel_s  <= 2'b11;
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end
        else
        begin
            sck_s  <= {sck_s[0], sck_i};
            mosi_s <= {mosi_s[0], mosi_i};
            miso_s <= {miso_s[0], miso_i};
            sel_s  <= {sel_s[0], sel_n_i};
            sck_d_r <= sck_s[1];
            sel_d_r <= sel_s[1];
        end
    end

    assign sel_fall   = sel_d_r && !sel_s[1];
    assign fault_cond = master && ctrl_r[spisd_pkg::CTL_FAULT_DETECT_EN]
                        && !ctrl_r[spisd_pkg::CTL_SELECT_OUT_EN] && !sel_s[1]; // R8
    assign tick       = (div_cnt_r == div_r);
    // Slave edges follow clock polarity: leading edge is away from idle level
    assign lead_edge  = master ? (state_r == spisd_pkg::ST_RUN && tick && !edge_cnt_r[0])
                        : (sck_s[1] != sck_d_r) && (sck_s[1] != ctrl_r[spisd_pkg::CTL_CLOCK_POLARITY]);
    assign trail_edge = master ? (state_r == spisd_pkg::ST_RUN && tick && edge_cnt_r[0])
                        : (sck_s[1] != sck_d_r) && (sck_s[1] == ctrl_r[spisd_pkg::CTL_CLOCK_POLARITY]);
    assign sample_edge = phase ? trail_edge : lead_edge; // R14
    assign sin        = master ? miso_s[1] : mosi_s[1];
    // A frame ends on its sixteenth serial edge in both phases
    assign done       = (state_r == spisd_pkg::ST_RUN) && trail_edge
                        && (edge_cnt_r == 4'(2 * spisd_pkg::BITS_PER_XFER - 1)); // R14
    // Phase 0 samples its last bit half a cycle before the frame ends
    assign last_bit   = phase ? sin : miso_bit_r;

    // Shifter is free when no transfer runs; in slave mode it waits for select
    // Phase 0 idles one cycle between frames so the select line rises
    assign load = txfull_r && (state_r == spisd_pkg::ST_IDLE || (done && phase))
                  && (master || !sel_s[1]); // R6 R7 R16 R19

    // Control register one and divider
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= spisd_pkg::CTRL1_RESET;
            div_r  <= spisd_pkg::DIV_RESET;
        end
        else
        begin
            if (wr_ok && wb_adr_i == spisd_pkg::ADR_CTRL1)
                ctrl_r[7:0] <= wb_dat_i[7:0];
            if (wr_ok && wb_adr_i == 4'h1)
                ctrl_r[spisd_pkg::CTL_FAULT_DETECT_EN] <= wb_dat_i[4];
            if (wr_ok && wb_adr_i == spisd_pkg::ADR_DIV)
                div_r <= wb_dat_i[7:0];
            if (fault_cond)
                ctrl_r[spisd_pkg::CTL_MASTER_SELECT] <= 1'b0; // R21
        end
    end

    // Clear sequences armed only by a status read seeing the flag set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            arm_rx_r    <= 1'b0;
            arm_tx_r    <= 1'b0;
            arm_fault_r <= 1'b0;
        end
        else if (rd_ok && wb_adr_i == spisd_pkg::ADR_FLAGS)
        begin
            arm_rx_r    <= rx_full_flag_r; // R23
            arm_tx_r    <= tx_empty_flag; // R23
            arm_fault_r <= mode_fault_flag_r; // R23
        end
        else
        begin
            if (rd_ok && wb_adr_i == spisd_pkg::ADR_BUFFER)
                arm_rx_r <= 1'b0;
            if (wr_ok && wb_adr_i == spisd_pkg::ADR_BUFFER)
                arm_tx_r <= 1'b0;
            if (wr_ok && wb_adr_i == spisd_pkg::ADR_CTRL1)
                arm_fault_r <= 1'b0;
        end
    end

    // Transmit buffer; a load into the shifter frees it in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            txbuf_r  <= spisd_pkg::BUFFER_RESET;
            txfull_r <= 1'b0;
        end
        else
        begin
            if (wr_ok && wb_adr_i == spisd_pkg::ADR_BUFFER && arm_tx_r && !txfull_r)
            begin
                txbuf_r  <= wb_dat_i[7:0]; // R3 R11
                txfull_r <= 1'b1; // R2
            end
            else if (load)
                txfull_r <= 1'b0; // R5
        end
    end

    // Receive buffer and flag; set wins over the clearing read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rxbuf_r        <= spisd_pkg::BUFFER_RESET;
            rx_full_flag_r <= 1'b0;
        end
        else if (done && !(rx_full_flag_r && !(rd_ok && wb_adr_i == spisd_pkg::ADR_BUFFER && arm_rx_r)))
        begin
            rxbuf_r        <= ctrl_r[spisd_pkg::CTL_LSB_FIRST_EN] ? {last_bit, shift_r[7:1]}
                                                                  : {shift_r[6:0], last_bit}; // R15
            rx_full_flag_r <= 1'b1; // R1
        end
        else if (done)
            rx_full_flag_r <= 1'b1; // R12
        else if (rd_ok && wb_adr_i == spisd_pkg::ADR_BUFFER && arm_rx_r)
            rx_full_flag_r <= 1'b0; // R1
    end

    // Mode fault flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_fault_flag_r <= 1'b0;
        else if (fault_cond)
            mode_fault_flag_r <= 1'b1; // R8
        else if (wr_ok && wb_adr_i == spisd_pkg::ADR_CTRL1 && arm_fault_r)
            mode_fault_flag_r <= 1'b0; // R9
    end

    // Transfer sequencer and shifter
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r    <= spisd_pkg::ST_IDLE;
            shift_r    <= 8'h00;
            edge_cnt_r <= 4'h0;
            div_cnt_r  <= 8'h00;
            sck_r      <= 1'b0;
            miso_bit_r <= 1'b0;
            out_r      <= 1'b0;
        end
        else
        begin
            div_cnt_r <= (state_r == spisd_pkg::ST_IDLE || tick) ? 8'h00 : div_cnt_r + 8'h01;
            if (fault_cond || (!master && sel_s[1] && state_r != spisd_pkg::ST_IDLE && !phase))
                state_r <= spisd_pkg::ST_IDLE; // R18 R19
            else if (load)
            begin
                shift_r    <= txbuf_r; // R16
                edge_cnt_r <= 4'h0;
                state_r    <= spisd_pkg::ST_RUN;
                out_r      <= ctrl_r[spisd_pkg::CTL_LSB_FIRST_EN] ? txbuf_r[0] : txbuf_r[7]; // R17
            end
            else if (done)
                state_r <= spisd_pkg::ST_IDLE; // R7
            else if (state_r == spisd_pkg::ST_RUN)
            begin
                if (lead_edge || trail_edge)
                begin
                    edge_cnt_r <= edge_cnt_r + 4'h1;
                    if (master)
                        sck_r <= ~sck_r;
                end
                if (sample_edge)
                    miso_bit_r <= sin; // R14
                else if ((phase ? lead_edge : trail_edge) && (edge_cnt_r != 4'h0 || !phase))
                begin
                    // Output changes half a serial cycle after the sample
                    shift_r <= ctrl_r[spisd_pkg::CTL_LSB_FIRST_EN] ? {miso_bit_r, shift_r[7:1]}
                                                                   : {shift_r[6:0], miso_bit_r};
                    out_r   <= ctrl_r[spisd_pkg::CTL_LSB_FIRST_EN] ? shift_r[1] : shift_r[6]; // R17
                end
            end
            // The closing edge of a frame returns the clock to idle
            if (state_r == spisd_pkg::ST_IDLE || done)
                sck_r <= 1'b0;
        end
    end

    assign sck_o      = sck_r ^ ctrl_r[spisd_pkg::CTL_CLOCK_POLARITY];
    assign sck_oe_o   = master && ctrl_r[spisd_pkg::CTL_SPI_ENABLE]; // R21
    assign mosi_o     = out_r;
    assign mosi_oe_o  = master && ctrl_r[spisd_pkg::CTL_SPI_ENABLE]; // R21
    assign miso_o     = out_r;
    assign miso_oe_o  = !master && ctrl_r[spisd_pkg::CTL_SPI_ENABLE] && !sel_s[1];
    assign sel_n_o    = !(state_r == spisd_pkg::ST_RUN);
    assign sel_n_oe_o = master && ctrl_r[spisd_pkg::CTL_FAULT_DETECT_EN] && ctrl_r[spisd_pkg::CTL_SELECT_OUT_EN];
    assign irq_o      = (tx_empty_flag && ctrl_r[spisd_pkg::CTL_TX_IRQ_EN]) // R4
                        || ((rx_full_flag_r || mode_fault_flag_r) && ctrl_r[spisd_pkg::CTL_RX_FAULT_IRQ_EN]); // R22
endmodule

// [test/spisd_core_assertions.sv]
// Port-level assertions for the SPI status/data block
`timescale 1ns/100ps
module spisd_checker
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sck_o,
    input wire logic        sck_oe_o,
    input wire logic        mosi_o,
    input wire logic        mosi_oe_o,
    input wire logic        sel_n_o,
    input wire logic        sel_n_oe_o,
    input wire logic        irq_o
);
    logic [3:0] cfg_r;
    logic       sck_q;
    logic [3:0] edges_r;
    wire        wr_ctl = wb_ack_o && wb_we_i && wb_adr_i == spisd_pkg::ADR_CTRL1 && wb_sel_i[0];
    wire        rd_flg = wb_ack_o && !wb_we_i && wb_adr_i == spisd_pkg::ADR_FLAGS;
    // Sample edge depends on polarity and phase; tracked from control writes
    wire        smp = sck_o != sck_q && sck_o == (cfg_r[3] ~^ cfg_r[2]);
    always_ff @(posedge clk_i)
        if (rst_i)
            cfg_r <= 4'h0;
        else if (wr_ctl)
            cfg_r <= {wb_dat_i[3:2], wb_dat_i[5], wb_dat_i[7]};
    always_ff @(posedge clk_i)
        sck_q <= sck_o;
    always_ff @(posedge clk_i)
        if (rst_i || sel_n_o)
            edges_r <= 4'h0;
        else if (sck_o && !sck_q)
            edges_r <= edges_r + 4'h1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse;
    endproperty
    property p_flags;
        rd_flg |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[6] && wb_dat_o[3:0] == 4'h0;
    endproperty
    property p_fault;
        rd_flg && wb_dat_o[spisd_pkg::FLG_MODE_FAULT] |-> !sck_oe_o && !mosi_oe_o;
    endproperty
    property p_irq_tx;
        rd_flg && wb_dat_o[spisd_pkg::FLG_TX_EMPTY] && cfg_r[1] |-> irq_o;
    endproperty
    property p_irq_rf;
        rd_flg && (wb_dat_o[7] || wb_dat_o[4]) && cfg_r[0] |-> irq_o;
    endproperty
    property p_eight;
        $rose(sel_n_o) && sel_n_oe_o |-> edges_r == 4'h8;
    endproperty
    property p_mosi;
        smp && !sel_n_o && sel_n_oe_o && mosi_oe_o |-> $stable(mosi_o);
    endproperty
    property p_reset;
        $fell(rst_i) |-> !irq_o && !sck_oe_o && !mosi_oe_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    a_flags: assert property (p_flags) else $error("unused flag bits set");
    a_fault: assert property (p_fault) else $error("drivers on after fault");
    a_irq_tx: assert property (p_irq_tx) else $error("tx irq missing");
    a_irq_rf: assert property (p_irq_rf) else $error("rx fault irq missing");
    a_eight: assert property (p_eight) else $error("frame not eight clocks");
    a_mosi: assert property (p_mosi) else $error("data moved at sample edge");
    a_reset: assert property (p_reset) else $error("not quiet after reset");
endmodule
bind spisd_core spisd_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sck_o, .sck_oe_o, .mosi_o, .mosi_oe_o, .sel_n_o, .sel_n_oe_o, .irq_o);

// [test/spisd_slave_model.sv]
// Behavioural SPI slave for clock polarity 0, phase 0
`timescale 1ns/100ps
module spisd_slave_model
(
    input  wire logic       sck_i,
    input  wire logic       sel_n_i,
    input  wire logic       mosi_i,
    input  wire logic [7:0] reply_i,
    output logic            miso_o,
    output logic [7:0]      got_o,
    output int              frames_o
);
    logic [7:0] sh_r;
    logic [7:0] rx_r;
    logic       armed_r;
    initial
    begin
        miso_o = 1'b0;
        frames_o = 0;
        armed_r = 1'b0;
    end
    // Reply changes per frame so a dropped byte shows
    always @(negedge sel_n_i)
    begin
        sh_r = reply_i + frames_o[7:0];
        miso_o = sh_r[7];
        armed_r = 1'b1;
    end
    always @(posedge sck_i)
        if (!sel_n_i)
            rx_r = {rx_r[6:0], mosi_i};
    always @(negedge sck_i)
        if (!sel_n_i)
        begin
            sh_r = {sh_r[6:0], 1'b0};
            miso_o = sh_r[7];
        end
    // Released line shows no stale bit
    always @(posedge sel_n_i)
        if (armed_r)
        begin
            got_o = rx_r;
            frames_o = frames_o + 1;
            miso_o = ~miso_o;
        end
endmodule

// [test/testbench.sv]
// Self-checking bench for the SPI status/data block
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic we; logic [3:0] adr; logic [7:0] d; logic [7:0] exp;} spisd_row_s;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic        ext_sel_n = 1'b1;
    logic [31:0] rdat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, sel_n_o, sel_n_oe_o, irq_o, miso_w;
    logic [7:0]  got;
    int          frames;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // Clock pulled low and data pulled high when undriven
    wire         sck_w = sck_oe_o === 1'b1 ? sck_o : 1'b0;
    wire         mosi_w = mosi_oe_o === 1'b1 ? mosi_o : 1'b1;
    wire         sel_w = sel_n_oe_o === 1'b1 ? sel_n_o : ext_sel_n;
    spisd_row_s  rows [7] = '{
        '{1'b0, spisd_pkg::ADR_BUFFER, 8'h00, 8'h00},
        '{1'b0, 4'hf, 8'h00, 8'h00},
        '{1'b1, 4'h1, 8'h10, 8'h00},
        '{1'b1, spisd_pkg::ADR_CTRL1, 8'h72, 8'h00},
        '{1'b1, spisd_pkg::ADR_BUFFER, 8'h11, 8'h00},
        '{1'b1, spisd_pkg::ADR_FLAGS, 8'hff, 8'h00},
        '{1'b0, spisd_pkg::ADR_FLAGS, 8'h00, 8'h20}};
    spisd_core dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
        .miso_i(miso_w), .miso_o(), .miso_oe_o(), .sel_n_i(sel_w), .sel_n_o, .sel_n_oe_o, .irq_o);
    spisd_slave_model slave (.sck_i(sck_w), .sel_n_i(sel_w), .mosi_i(mosi_w), .reply_i(8'h3c),
        .miso_o(miso_w), .got_o(got), .frames_o(frames));
    always #50 clk_i = ~clk_i;
    task automatic conclude;
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
        num_checks++;
        if (got_v !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got_v);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register read", {24'h0, e}, rdat);
    endtask
    task automatic wait_frames(input int n);
        while (frames < n)
            @(posedge clk_i);
        repeat (4) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            bus(rows[i].we, rows[i].adr, rows[i].d);
            if (!rows[i].we)
                chk("table read", {24'h0, rows[i].exp}, rdat);
        end
        chk("tx irq", 32'h1, {31'h0, irq_o});
        repeat (100) @(posedge clk_i);
        chk("frames", 32'h0, frames);
        bus(1'b1, spisd_pkg::ADR_BUFFER, 8'ha5);
        @(posedge clk_i);
        rdc(spisd_pkg::ADR_FLAGS, 8'h20);
        bus(1'b1, spisd_pkg::ADR_BUFFER, 8'hc3);
        rdc(spisd_pkg::ADR_FLAGS, 8'h00);
        bus(1'b1, spisd_pkg::ADR_BUFFER, 8'h77);
        wait_frames(1);
        chk("slave got", 32'ha5, {24'h0, got});
        wait_frames(2);
        chk("slave got", 32'hc3, {24'h0, got});
        repeat (100) @(posedge clk_i);
        chk("frames", 32'h2, frames);
        rdc(spisd_pkg::ADR_FLAGS, 8'ha0);
        rdc(spisd_pkg::ADR_BUFFER, 8'h3c);
        rdc(spisd_pkg::ADR_FLAGS, 8'h20);
        bus(1'b1, spisd_pkg::ADR_CTRL1, 8'h53);
        rdc(spisd_pkg::ADR_FLAGS, 8'h20);
        bus(1'b1, spisd_pkg::ADR_BUFFER, 8'h01);
        wait_frames(3);
        chk("slave got", 32'h80, {24'h0, got});
        rdc(spisd_pkg::ADR_FLAGS, 8'ha0);
        rdc(spisd_pkg::ADR_BUFFER, 8'h7c);
        bus(1'b1, spisd_pkg::ADR_CTRL1, 8'hd0);
        chk("irq", 32'h0, {31'h0, irq_o});
        ext_sel_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        rdc(spisd_pkg::ADR_FLAGS, 8'h30);
        chk("sck oe", 32'h0, {31'h0, sck_oe_o});
        chk("irq", 32'h1, {31'h0, irq_o});
        ext_sel_n <= 1'b1;
        bus(1'b1, spisd_pkg::ADR_CTRL1, 8'h00);
        rdc(spisd_pkg::ADR_FLAGS, 8'h20);
        bus(1'b1, spisd_pkg::ADR_CTRL1, 8'h20);
        chk("irq", 32'h1, {31'h0, irq_o});
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("irq", 32'h0, {31'h0, irq_o});
        rdc(spisd_pkg::ADR_FLAGS, 8'h20);
        conclude();
    end
endmodule
